// *** spi_port_pkg.sv ***
// Constants for the serial register port
package spi_port_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int FRAME_BITS = ADDR_W + 1 + DATA_W;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] CMD_BIT_IDX = 5'h09;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 5'h19;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 5'h00;
    localparam logic [BIT_CNT_W-1:0] BIT_STEP = 5'h01;
    localparam logic [BIT_CNT_W-1:0] ADDR_LAST_IDX = 5'h08;
    localparam logic [BIT_CNT_W-1:0] TX_LOAD_IDX = 5'h0a;
    localparam logic [BIT_CNT_W-1:0] TX_BITS = 5'h10;
    localparam logic [BIT_CNT_W-1:0] TX_NONE = 5'h00;
    localparam logic [BIT_CNT_W-1:0] TX_FINAL = 5'h01;
    localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
    localparam int REG_COUNT = 512;
    localparam int SCK_PERIOD_NS = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic CMD_WRITE = 1'b1;
endpackage

// *** reg_mem.sv ***
// Register storage, one write port, registered read port
module reg_mem
    import spi_port_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:REG_COUNT-1];

    initial
    begin
        for (int i = 0; i < REG_COUNT; i++)
            mem[i] = REG_RST;
    end

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule

// *** spi_reg_port.sv ***
// Serial slave register port with system clock register store
module spi_reg_port
    import spi_port_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCK,
    input wire logic SS_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE
);
    // Link domain
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [ADDR_W-1:0] addr_sh;
    logic [DATA_W-1:0] data_sh;
    logic is_write;
    logic [ADDR_W-1:0] wr_addr_hold;
    logic [DATA_W-1:0] wr_data_hold;
    logic wr_toggle = 1'b0;
    logic rd_toggle = 1'b0;
    logic [ADDR_W-1:0] rd_addr_hold;
    logic [DATA_W-1:0] tx_sh;
    logic tx_active;
    logic [BIT_CNT_W-1:0] tx_left;

    // System domain
    logic wr_sync1, wr_sync2, wr_sync3;
    logic rd_sync1, rd_sync2, rd_sync3;
    logic mem_we;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] rd_word;
    logic rd_pend;
    logic [ADDR_W-1:0] mem_raddr;
    logic rd_req;

    // Toggle synchroniser edge: one pulse per event
    function automatic logic toggle_event(
        input logic newer,
        input logic older
    );
        return newer ^ older;
    endfunction

    // Frame position decode
    wire in_addr = bit_cnt < CMD_BIT_IDX;
    wire at_cmd = bit_cnt == CMD_BIT_IDX;
    wire at_last = bit_cnt == LAST_BIT_IDX;
    wire frame_done = bit_cnt > LAST_BIT_IDX;
    wire in_data = bit_cnt > CMD_BIT_IDX && !frame_done;
    wire addr_whole = !SS_N && bit_cnt == ADDR_LAST_IDX;
    wire wr_capture = !SS_N && at_last && is_write;
    wire tx_idle = !tx_active && tx_left == TX_NONE;
    wire tx_start = bit_cnt == TX_LOAD_IDX && !is_write && tx_idle;
    wire tx_final = tx_left == TX_FINAL;

    // Bit position in the frame; select high clears it
    always_ff @(posedge SCK or posedge SS_N)
    begin
        if (SS_N)
            bit_cnt <= BIT_CNT_RST;
        else if (!frame_done)
            bit_cnt <= bit_cnt + BIT_STEP;
    end

    // Address bits, MSB first
    always_ff @(posedge SCK or posedge SS_N)
    begin
        if (SS_N)
            addr_sh <= '0;
        else if (in_addr)
            addr_sh <= {addr_sh[ADDR_W-2:0], MOSI};
    end

    // Command bit
    always_ff @(posedge SCK or posedge SS_N)
    begin
        if (SS_N)
            is_write <= 1'b0;
        else if (at_cmd)
            is_write <= MOSI == CMD_WRITE;
    end

    // Write data bits, MSB first
    always_ff @(posedge SCK or posedge SS_N)
    begin
        if (SS_N)
            data_sh <= '0;
        else if (in_data)
            data_sh <= {data_sh[DATA_W-2:0], MOSI};
    end

    // Only a complete write frame raises the event
    always_ff @(posedge SCK)
    begin
        if (wr_capture)
        begin
            wr_addr_hold <= addr_sh;
            wr_data_hold <= {data_sh[DATA_W-2:0], MOSI};
            wr_toggle <= ~wr_toggle;
        end
    end

    // Fetch starts before the command bit so data is ready in time
    always_ff @(posedge SCK)
    begin
        if (addr_whole)
        begin
            rd_addr_hold <= {addr_sh[ADDR_W-2:0], MOSI};
            rd_toggle <= ~rd_toggle;
        end
    end

    // Return shifter on falling edges
    // Fetched word settles about four system cycles after the
    // ninth rising edge, well before this load edge
    always_ff @(negedge SCK or posedge SS_N)
    begin
        if (SS_N)
            tx_sh <= '0;
        else if (tx_start)
            tx_sh <= rd_word;
        else if (tx_active)
            tx_sh <= {tx_sh[DATA_W-2:0], 1'b0};
    end

    // Bits still to go out; drive only meanwhile
    always_ff @(negedge SCK or posedge SS_N)
    begin
        if (SS_N)
        begin
            tx_active <= 1'b0;
            tx_left <= TX_NONE;
        end
        else if (tx_start)
        begin
            tx_active <= 1'b1;
            tx_left <= TX_BITS;
        end
        else if (tx_active)
        begin
            tx_left <= tx_left - BIT_STEP;
            if (tx_final)
                tx_active <= 1'b0;
        end
    end

    assign MISO = tx_sh[DATA_W-1];
    assign MISO_OE = tx_active;

    // Write event synchroniser
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wr_sync1 <= 1'b0;
            wr_sync2 <= 1'b0;
            wr_sync3 <= 1'b0;
        end
        else
        begin
            wr_sync1 <= wr_toggle;
            wr_sync2 <= wr_sync1;
            wr_sync3 <= wr_sync2;
        end
    end

    // Read event synchroniser
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rd_sync1 <= 1'b0;
            rd_sync2 <= 1'b0;
            rd_sync3 <= 1'b0;
        end
        else
        begin
            rd_sync1 <= rd_toggle;
            rd_sync2 <= rd_sync1;
            rd_sync3 <= rd_sync2;
        end
    end

    // Held words are stable once their toggle arrives
    assign mem_we = toggle_event(wr_sync2, wr_sync3);
    assign rd_req = toggle_event(rd_sync2, rd_sync3);
    assign mem_raddr = rd_addr_hold;

    // Memory answers one cycle after the request
    always_ff @(posedge CLK)
    begin
        if (RST)
            rd_pend <= 1'b0;
        else
            rd_pend <= rd_req;
    end

    // Word handed to the link
    always_ff @(posedge CLK)
    begin
        if (rd_pend)
            rd_word <= mem_rdata;
    end

    reg_mem u_mem (
        .clk(CLK),
        .we(mem_we),
        .waddr(wr_addr_hold),
        .wdata(wr_data_hold),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );
endmodule

// *** spi_reg_port_properties.sv ***
// Serial frame checker for the register port
module spi_reg_port_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCK,
    input wire logic SS_N,
    input wire logic MOSI,
    input wire logic MISO,
    input wire logic MISO_OE
);
    logic [4:0] cnt;
    logic cmd;
    always_ff @(posedge SCK or posedge SS_N)
    begin
        if (SS_N)
        begin
            cnt <= 5'h00;
            cmd <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h09)
                cmd <= MOSI;
        end
    end
    default clocking cb @(negedge SCK);
    endclocking
    default disable iff (SS_N);
    sequence s_burst;
        MISO_OE [*8] ##1 MISO_OE [*8];
    endsequence
    property p_pre; cnt < 5'h0b |-> !MISO_OE; endproperty
    property p_cmd; cnt == 5'h0a |=> MISO_OE != cmd; endproperty
    property p_rose; $rose(MISO_OE) |-> cnt == 5'h0b && !cmd; endproperty
    property p_rd; cnt == 5'h0b && !cmd |-> s_burst; endproperty
    property p_hold; MISO_OE && cnt < 5'h1a |=> MISO_OE; endproperty
    property p_wr; cmd |-> !MISO_OE; endproperty
    property p_end; cnt > 5'h1a |-> !MISO_OE; endproperty
    property p_len; $fell(MISO_OE) && cnt > 5'h01 |-> cnt == 5'h1b; endproperty
    a_pre: assert property (p_pre) else $error("oe early");
    a_cmd: assert property (p_cmd) else $error("oe vs cmd");
    a_rose: assert property (p_rose) else $error("oe start");
    a_rd: assert property (p_rd) else $error("short read");
    a_hold: assert property (p_hold) else $error("oe gap");
    a_wr: assert property (p_wr) else $error("oe in write");
    a_end: assert property (p_end) else $error("oe late");
    a_len: assert property (p_len) else $error("oe length");
endmodule
bind spi_reg_port spi_reg_port_properties chk_u (.CLK(CLK), .RST(RST),
    .SCK(SCK), .SS_N(SS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE));

// *** spi_master_model.sv ***
// Serial master model for the register port
module spi_master_model (
    output logic SCK,
    output logic SS_N,
    output logic MOSI,
    input wire logic MISO,
    input wire logic MISO_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        SCK = 1'b0;
        SS_N = 1'b1;
        MOSI = 1'b0;
    end
    task automatic xfer(input logic [25:0] f, input int n, output logic [15:0] q);
        SS_N = 1'b0;
        #80;
        for (int i = 0; i < n; i++)
        begin
            MOSI = (i < 26) ? f[25 - i] : 1'b0;
            #40 SCK = 1'b1;
            #40 if (i > 9 && i < 26) q = {q[14:0], MISO};
            SCK = 1'b0;
        end
        #80 SS_N = 1'b1;
        MOSI = ~MOSI;
        #160;
    endtask
endmodule

// *** sensor_spi_register_port_tb.sv ***
// Self-checking bench for the serial register port
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module sensor_spi_register_port_tb
    import spi_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    wire SCK, SS_N, MOSI, MISO, MISO_OE;
    int mismatches = 0;
    int checks_done = 0;
    logic [15:0] q;
    always #5 CLK = ~CLK;
    spi_reg_port dut_u (.CLK(CLK), .RST(RST), .SCK(SCK), .SS_N(SS_N), .MOSI(MOSI),
        .MISO(MISO), .MISO_OE(MISO_OE));
    spi_master_model m_u (.SCK(SCK), .SS_N(SS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE));
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        m_u.xfer({a, 1'b0, 16'h0000}, 26, q);
        `CHK("rdata", e, q)
    endtask
    task automatic t_reset();
        `CHK("oe_idle", 1'b0, MISO_OE)
        rd(9'h1ff, REG_RST);
        $display("t_reset done");
    endtask
    task automatic t_wr();
        m_u.xfer({9'h000, CMD_WRITE, 16'ha5c3}, 26, q);
        m_u.xfer({9'h1ff, CMD_WRITE, 16'h5a3c}, 26, q);
        rd(9'h000, 16'ha5c3);
        rd(9'h1ff, 16'h5a3c);
        $display("t_wr done");
    endtask
    task automatic t_abort();
        m_u.xfer({9'h000, CMD_WRITE, 16'h0000}, 25, q);
        m_u.xfer({9'h000, 1'b0, 16'hffff}, 28, q);
        `CHK("rdata", 16'ha5c3, q)
        rd(9'h000, 16'ha5c3);
        $display("t_abort done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge CLK);
        RST = 1'b0;
        repeat (2) @(negedge CLK);
        #3;
        t_reset();
        t_wr();
        t_abort();
        complete_run();
    end
    initial
    begin
        #60000;
        mismatches++;
        complete_run();
    end
endmodule
